// ===== rtl/seirq_defines.vh
`ifndef SEIRQ_DEFINES_VH
`define SEIRQ_DEFINES_VH

// register indices; byte address is four times the index
`define SEIRQ_IDX_NORM_STAT   8'h30
`define SEIRQ_IDX_ERR_STAT    8'h32
`define SEIRQ_IDX_NORM_EN     8'h34
`define SEIRQ_IDX_ERR_EN      8'h36
`define SEIRQ_IDX_NORM_SIG    8'h38
`define SEIRQ_IDX_ERR_SIG     8'h3A

// field widths and positions
`define SEIRQ_NORM_W          13
`define SEIRQ_ERR_W           11
`define SEIRQ_W1C_W           8
`define SEIRQ_BIT_TUNE        10
`define SEIRQ_BIT_ADMA        9
`define SEIRQ_BIT_ASTOP       8
`define SEIRQ_BIT_CURLIM      7
`define SEIRQ_BIT_DEND        6
`define SEIRQ_BIT_DCRC        5
`define SEIRQ_BIT_DTO         4
`define SEIRQ_BIT_CIDX        3
`define SEIRQ_BIT_CEND        2
`define SEIRQ_BIT_CCRC        1
`define SEIRQ_BIT_CTO         0
`define SEIRQ_BIT_RETUNE      12
`define SEIRQ_BIT_LINE_C      11
`define SEIRQ_BIT_LINE_B      10
`define SEIRQ_BIT_LINE_A      9
`define SEIRQ_BIT_CARD        8

// reset values
`define SEIRQ_RST_NORM        13'h0000
`define SEIRQ_RST_ERR         11'h000
`define SEIRQ_RST_W1C         8'h00

// good write crc status token
`define SEIRQ_CRC_TOKEN_OK    3'h2

// command response wait, in card clock cycles
`define SEIRQ_CMD_TO_CLKS     7'h40
`define SEIRQ_CNT_ZERO        7'h00
`define SEIRQ_CNT_ONE         7'h01

`endif

// ===== rtl/seirq_sync.v
// three-stage synchroniser; output moves only once stages two and three agree
module seirq_sync (
   input  wire sys_clk_in,
   input  wire rstn_in,
   input  wire pin_in,
   output wire level_out
);
   reg s1_q;  // first stage, read only by s2_q
   reg s2_q;  // second stage
   reg s3_q;  // third stage
   reg lvl_q; // filtered level

   // all stages reset high so idle active-low pins start inactive
   always @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         s1_q  <= 1'b1;
         s2_q  <= 1'b1;
         s3_q  <= 1'b1;
         lvl_q <= 1'b1;
      end else begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         // a single-cycle glitch between stages never reaches the level
         if (s2_q == s3_q) begin
            lvl_q <= s3_q;
         end
      end
   end

   assign level_out = lvl_q;
endmodule // seirq_sync

// ===== rtl/seirq_core.v
// The AHB-Lite slave port was left to the implementer.
`include "seirq_defines.vh"

// Summary of operation
// - error latched only while its enable is set
// - tuning fault outside tuning sets bit 10
// - tuning fault outranks other transfer errors
// - advanced dma fault or invalid descriptor: bit 9
// - any auto stop command fault sets bit 8
// - bit 7 shows overcurrent power withdrawal
// - zero data end bit sets bit 6
// - data crc or bad token sets bit 5
// - any of four data timeouts: bit 4
// - response index mismatch sets bit 3
// - zero response end bit sets bit 2
// - response crc mismatch sets bit 1
// - no response in 64 card clocks: bit 0
// - normal source latched only when enabled
// - enable bit 15 reads zero in both
// - clearing shared-line enable withdraws its request
// - card interrupt sampling follows enable bit 8
// - signal enables route statuses to one line
// - bit 15 summary shows any error flag
module seirq_core (
   input  wire        sys_clk_in,
   input  wire        rstn_in,
   // ahb-lite slave
   input  wire        hsel_in,
   input  wire [31:0] haddr_in,
   input  wire [1:0]  htrans_in,
   input  wire        hwrite_in,
   input  wire [2:0]  hsize_in,
   input  wire [31:0] hwdata_in,
   input  wire        hready_in,
   output wire        hreadyout_out,
   output wire        hresp_out,
   output wire [31:0] hrdata_out,
   // error sources, one-cycle pulses unless noted
   input  wire        tuning_fault_in,
   input  wire        tuning_active_in,
   input  wire        xfer_active_in,
   input  wire        adma_fault_in,
   input  wire        desc_fetched_in,
   input  wire        desc_valid_in,
   input  wire [4:0]  auto_stop_faults_in,
   input  wire        power_withdrawn_in,
   input  wire        data_end_bit_zero_in,
   input  wire        read_crc_bad_in,
   input  wire        wr_token_valid_in,
   input  wire [2:0]  wr_token_in,
   input  wire        data_timeout_in,
   input  wire        cmd_sent_in,
   input  wire [5:0]  cmd_issued_idx_in,
   input  wire        resp_start_in,
   input  wire        resp_done_in,
   input  wire [5:0]  resp_idx_in,
   input  wire        resp_end_bit_in,
   input  wire        resp_crc_ok_in,
   input  wire        sd_clk_in,
   // normal sources
   input  wire        retune_req_in,
   input  wire        int_a_n_in,
   input  wire        int_b_n_in,
   input  wire        int_c_n_in,
   input  wire        card_irq_n_in,
   input  wire [7:0]  normal_event_in,
   // shared interrupt line to the system
   output wire        irq_out
);

   // byte address of a register from its index
   function [9:0] reg_addr;
      input [7:0] idx;
      begin
         reg_addr = {idx, 2'b00};
      end
   endfunction

   // sticky flag update where a new event beats a clear in the same cycle
   function [`SEIRQ_ERR_W-1:0] w1c_next;
      input [`SEIRQ_ERR_W-1:0] cur;
      input [`SEIRQ_ERR_W-1:0] clr;
      input [`SEIRQ_ERR_W-1:0] set;
      begin
         w1c_next = (cur & ~clr) | set;
      end
   endfunction

   // register bank and bus pipeline state
   reg  [`SEIRQ_ERR_W-1:0]  err_flags_q;              // error_event_flags
   reg  [`SEIRQ_ERR_W-1:0]  err_flags_d;
   reg  [`SEIRQ_ERR_W-1:0]  error_latch_enable_reg;   // error_event_latch_enable
   reg  [`SEIRQ_ERR_W-1:0]  err_sig_en_q;             // error signal enable
   reg  [`SEIRQ_NORM_W-1:0] norm_en_q;                // normal_event_latch_enable
   reg  [`SEIRQ_NORM_W-1:0] norm_sig_en_q;            // normal_event_signal_enable
   reg  [`SEIRQ_W1C_W-1:0]  norm_w1c_q;               // normal bits 7..0
   reg  [`SEIRQ_W1C_W-1:0]  norm_w1c_d;
   reg  [9:0]               dp_addr_q;                // captured address phase
   reg                      dp_write_q;               // data phase is a write
   reg  [31:0]              hrdata_q;                 // read data for data phase
   reg  [6:0]               cto_cnt_q;                // card clocks since command
   reg                      cto_run_q;                // waiting for a response
   reg                      sdclk_prev_q;             // edge detect on card clock
   reg  [`SEIRQ_ERR_W-1:0]  err_evt;                  // raw error events
   reg  [31:0]              rd_mux;                   // read decode
   reg                      cto_fire;                 // timeout reached
   reg                      irq_q;                    // registered shared line

   wire        a_lvl_n;     // synchronised shared line a
   wire        b_lvl_n;     // synchronised shared line b
   wire        c_lvl_n;     // synchronised shared line c
   wire        card_lvl_n;  // synchronised card interrupt
   wire        sdclk_lvl;   // synchronised card clock
   wire        addr_phase;  // valid transfer taken this edge
   wire        wr_go;       // write data present this cycle
   wire [15:0] wdat;        // low halfword of write data
   wire [`SEIRQ_NORM_W-1:0] norm_stat;  // assembled normal status
   wire        err_any;     // summary error flag

   wire        irq_next;    // shared line before its flop

   // named views of single enable bits
   wire retune_event_latch_en   = norm_en_q[`SEIRQ_BIT_RETUNE];
   wire shared_line_c_latch_en  = norm_en_q[`SEIRQ_BIT_LINE_C];
   wire shared_line_b_latch_en  = norm_en_q[`SEIRQ_BIT_LINE_B];
   wire shared_line_a_latch_en  = norm_en_q[`SEIRQ_BIT_LINE_A];
   wire card_request_latch_en   = norm_en_q[`SEIRQ_BIT_CARD];
   wire retune_event_route_en   = norm_sig_en_q[`SEIRQ_BIT_RETUNE];

   // pins from the card bus pass four flip-flops each
   seirq_sync u_sync_a (
      .sys_clk_in (sys_clk_in),
      .rstn_in    (rstn_in),
      .pin_in     (int_a_n_in),
      .level_out  (a_lvl_n)
   );
   seirq_sync u_sync_b (
      .sys_clk_in (sys_clk_in),
      .rstn_in    (rstn_in),
      .pin_in     (int_b_n_in),
      .level_out  (b_lvl_n)
   );
   seirq_sync u_sync_c (
      .sys_clk_in (sys_clk_in),
      .rstn_in    (rstn_in),
      .pin_in     (int_c_n_in),
      .level_out  (c_lvl_n)
   );
   seirq_sync u_sync_card (
      .sys_clk_in (sys_clk_in),
      .rstn_in    (rstn_in),
      .pin_in     (card_irq_n_in),
      .level_out  (card_lvl_n)
   );
   // the card clock passes the same filter; its edges are counted below
   seirq_sync u_sync_sdclk (
      .sys_clk_in (sys_clk_in),
      .rstn_in    (rstn_in),
      .pin_in     (sd_clk_in),
      .level_out  (sdclk_lvl)
   );

   // bus handshake: always ready, always okay
   assign hreadyout_out = 1'b1;
   assign hresp_out     = 1'b0;
   assign hrdata_out    = hrdata_q;
   assign addr_phase    = hsel_in & htrans_in[1] & hready_in;
   assign wr_go         = dp_write_q;
   // registers are 16 bits wide; the upper halfword of a write is dropped
   assign wdat          = hwdata_in[15:0];

   // command response timer counts card clock rising edges
   // the card clock is sampled on the bus clock, so it must stay well below
   // a quarter of it; faster card clocks lose edges and stretch the timeout
   always @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cto_cnt_q    <= `SEIRQ_CNT_ZERO;
         cto_run_q    <= 1'b0;
         sdclk_prev_q <= 1'b1;
      end else begin
         sdclk_prev_q <= sdclk_lvl;
         if (cmd_sent_in) begin
            cto_run_q <= 1'b1;
            cto_cnt_q <= `SEIRQ_CNT_ZERO;
         end else if (resp_start_in | cto_fire) begin
            // answer arrived or limit hit: stop waiting
            cto_run_q <= 1'b0;
         end else if (cto_run_q & sdclk_lvl & ~sdclk_prev_q) begin
            cto_cnt_q <= cto_cnt_q + `SEIRQ_CNT_ONE;
         end
      end
   end

   // timeout once the count has reached the response window
   always @* begin
      cto_fire = cto_run_q & ~resp_start_in & (cto_cnt_q == `SEIRQ_CMD_TO_CLKS);
   end

   // raw error events from the card-side detectors
   always @* begin
      err_evt = `SEIRQ_RST_ERR;
      // only outside a running tuning procedure
      err_evt[`SEIRQ_BIT_TUNE]   = tuning_fault_in & ~tuning_active_in;
      err_evt[`SEIRQ_BIT_ADMA]   = adma_fault_in | (desc_fetched_in & ~desc_valid_in);
      err_evt[`SEIRQ_BIT_ASTOP]  = |auto_stop_faults_in;
      err_evt[`SEIRQ_BIT_CURLIM] = power_withdrawn_in;
      err_evt[`SEIRQ_BIT_DEND]   = data_end_bit_zero_in;
      err_evt[`SEIRQ_BIT_DCRC]   = read_crc_bad_in |
                                   (wr_token_valid_in & (wr_token_in != `SEIRQ_CRC_TOKEN_OK));
      err_evt[`SEIRQ_BIT_DTO]    = data_timeout_in;
      err_evt[`SEIRQ_BIT_CIDX]   = resp_done_in & (resp_idx_in != cmd_issued_idx_in);
      err_evt[`SEIRQ_BIT_CEND]   = resp_done_in & ~resp_end_bit_in;
      err_evt[`SEIRQ_BIT_CCRC]   = resp_done_in & ~resp_crc_ok_in;
      err_evt[`SEIRQ_BIT_CTO]    = cto_fire;
      // a tuning fault during a transfer masks the other transfer errors
      // the held flag keeps masking until software clears it, so errors of
      // a transfer that will be discarded anyway stay hidden
      if ((err_evt[`SEIRQ_BIT_TUNE] | err_flags_q[`SEIRQ_BIT_TUNE]) & xfer_active_in) begin
         err_evt[`SEIRQ_BIT_ADMA] = 1'b0;
         err_evt[`SEIRQ_BIT_DEND] = 1'b0;
         err_evt[`SEIRQ_BIT_DCRC] = 1'b0;
         err_evt[`SEIRQ_BIT_DTO]  = 1'b0;
      end
   end

   // next value of the error flags
   // a clear written while the event is present loses; software reads back
   always @* begin
      if (wr_go & (dp_addr_q == reg_addr(`SEIRQ_IDX_ERR_STAT))) begin
         err_flags_d = w1c_next(err_flags_q, wdat[`SEIRQ_ERR_W-1:0],
                                err_evt & error_latch_enable_reg);
      end else begin
         err_flags_d = w1c_next(err_flags_q, `SEIRQ_RST_ERR,
                                err_evt & error_latch_enable_reg);
      end
      // overcurrent stays visible while power is withheld, even after a clear
      if (power_withdrawn_in & error_latch_enable_reg[`SEIRQ_BIT_CURLIM]) begin
         err_flags_d[`SEIRQ_BIT_CURLIM] = 1'b1;
      end
   end

   // next value of the sticky normal events
   always @* begin
      if (wr_go & (dp_addr_q == reg_addr(`SEIRQ_IDX_NORM_STAT))) begin
         norm_w1c_d = (norm_w1c_q & ~wdat[`SEIRQ_W1C_W-1:0]) |
                      (normal_event_in & norm_en_q[`SEIRQ_W1C_W-1:0]);
      end else begin
         norm_w1c_d = norm_w1c_q | (normal_event_in & norm_en_q[`SEIRQ_W1C_W-1:0]);
      end
   end

   // level-type statuses vanish as soon as their enable is cleared
   // writing one does not clear them; software masks the enable instead
   assign norm_stat = {retune_req_in & retune_event_latch_en,
                       ~c_lvl_n & shared_line_c_latch_en,
                       ~b_lvl_n & shared_line_b_latch_en,
                       ~a_lvl_n & shared_line_a_latch_en,
                       ~card_lvl_n & card_request_latch_en,
                       norm_w1c_q};
   assign err_any = |err_flags_q;

   // one shared line carries every routed status; it is registered so the
   // line cannot glitch while enables and flags change in one cycle
   assign irq_next = (|(norm_stat[`SEIRQ_BIT_RETUNE-1:0] & norm_sig_en_q[`SEIRQ_BIT_RETUNE-1:0])) |
                     (norm_stat[`SEIRQ_BIT_RETUNE] & retune_event_route_en) |
                     (|(err_flags_q & err_sig_en_q));
   assign irq_out  = irq_q;

   // read decode; bits above each field read zero
   // all 32 address bits are decoded; any other address reads zero, so an
   // alias of a register can never be mistaken for the register itself
   always @* begin
      rd_mux = 32'h00000000;
      case (haddr_in[9:0])
         reg_addr(`SEIRQ_IDX_NORM_STAT): rd_mux = {16'h0000, err_any, 2'b00, norm_stat};
         reg_addr(`SEIRQ_IDX_ERR_STAT):  rd_mux = {21'h000000, err_flags_q};
         reg_addr(`SEIRQ_IDX_NORM_EN):   rd_mux = {19'h00000, norm_en_q};
         reg_addr(`SEIRQ_IDX_ERR_EN):    rd_mux = {21'h000000, error_latch_enable_reg};
         reg_addr(`SEIRQ_IDX_NORM_SIG):  rd_mux = {19'h00000, norm_sig_en_q};
         reg_addr(`SEIRQ_IDX_ERR_SIG):   rd_mux = {21'h000000, err_sig_en_q};
         default:                        rd_mux = 32'h00000000;
      endcase
      // upper address bits must be clear for a hit
      if (haddr_in[31:10] != 22'h000000) begin
         rd_mux = 32'h00000000;
      end
   end

   // bus pipeline: capture address phase, apply write in data phase
   // transfer size is not checked: every register is taken as a whole word
   always @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         dp_addr_q  <= 10'h000;
         dp_write_q <= 1'b0;
         hrdata_q   <= 32'h00000000;
      end else begin
         dp_write_q <= addr_phase & hwrite_in & (haddr_in[31:10] == 22'h000000);
         if (addr_phase) begin
            dp_addr_q <= haddr_in[9:0];
         end
         // read data is sampled at the address phase, so a read straight after
         // a write to the same register returns the value before that write
         if (addr_phase & ~hwrite_in) begin
            hrdata_q <= rd_mux;
         end
      end
   end

   // status and enable registers
   always @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         err_flags_q            <= `SEIRQ_RST_ERR;
         error_latch_enable_reg <= `SEIRQ_RST_ERR;
         err_sig_en_q           <= `SEIRQ_RST_ERR;
         norm_en_q              <= `SEIRQ_RST_NORM;
         norm_sig_en_q          <= `SEIRQ_RST_NORM;
         norm_w1c_q             <= `SEIRQ_RST_W1C;
         irq_q                  <= 1'b0;
      end else begin
         err_flags_q <= err_flags_d;
         norm_w1c_q  <= norm_w1c_d;
         // line follows the routed statuses one edge later
         irq_q       <= irq_next;
         if (wr_go) begin
            // bit 15 and reserved bits are never stored
            if (dp_addr_q == reg_addr(`SEIRQ_IDX_NORM_EN)) begin
               norm_en_q <= wdat[`SEIRQ_NORM_W-1:0];
            end
            if (dp_addr_q == reg_addr(`SEIRQ_IDX_ERR_EN)) begin
               error_latch_enable_reg <= wdat[`SEIRQ_ERR_W-1:0];
            end
            if (dp_addr_q == reg_addr(`SEIRQ_IDX_NORM_SIG)) begin
               norm_sig_en_q <= wdat[`SEIRQ_NORM_W-1:0];
            end
            if (dp_addr_q == reg_addr(`SEIRQ_IDX_ERR_SIG)) begin
               err_sig_en_q <= wdat[`SEIRQ_ERR_W-1:0];
            end
         end
      end
   end

endmodule // seirq_core

// ===== testbench/seirq_chk.sv
module seirq_chk (
   input wire logic        sys_clk_in,
   input wire logic        rstn_in,
   input wire logic        hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0]  htrans_in,
   input wire logic        hwrite_in,
   input wire logic        hready_in,
   input wire logic        hreadyout_out,
   input wire logic        hresp_out,
   input wire logic [31:0] hrdata_out,
   input wire logic        cmd_sent_in,
   input wire logic        irq_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // read address phase as the slave takes it
   wire       rd_w  = hsel_in & htrans_in[1] & hready_in & ~hwrite_in;
   wire [7:0] idx_w = haddr_in[9:2];
   // upper address bits must be clear for a register hit
   wire       low_w = ~|haddr_in[31:10];
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!rstn_in);
   // slave never stalls or errs, so masters need no retry path
   okay_resp_a: assert property (hresp_out == 1'b0) else $error("error response seen");
   no_wait_a: assert property (hreadyout_out == 1'b1) else $error("wait state inserted");
   unmapped_zero_a: assert property (rd_w && !(low_w && idx_w inside {8'h30, 8'h32, 8'h34, 8'h36, 8'h38, 8'h3A})
      |=> hrdata_out == 32'h0) else $error("unmapped read not zero");
   err_rsvd_a: assert property (rd_w && low_w && idx_w inside {8'h32, 8'h36, 8'h3A}
      |=> hrdata_out[31:11] == 21'h0) else $error("reserved error bits not zero");
   en_top_zero_a: assert property (rd_w && low_w && idx_w inside {8'h34, 8'h38}
      |=> hrdata_out[31:13] == 19'h0) else $error("enable top bits not zero");
   stat_rsvd_a: assert property (rd_w && low_w && idx_w == 8'h30
      |=> hrdata_out[31:16] == 16'h0 && hrdata_out[14:13] == 2'h0) else $error("status gap bits not zero");
   // read data only moves when a read is taken
   read_hold_a: assert property (!rd_w |=> $stable(hrdata_out)) else $error("read data moved without read");
   irq_quiet_a: assert property ($rose(rstn_in) |-> !irq_out) else $error("line active after reset");
   err_read_c: cover property (rd_w && idx_w == 8'h32);
   irq_rise_c: cover property ($rose(irq_out));
   cmd_wait_c: cover property (cmd_sent_in ##1 !cmd_sent_in);
endmodule // seirq_chk

bind seirq_core seirq_chk u_chk (.sys_clk_in, .rstn_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hready_in,
   .hreadyout_out, .hresp_out, .hrdata_out, .cmd_sent_in, .irq_out);

// ===== testbench/seirq_host_model.sv
// host driver side: single word transfers on the register bus
module seirq_host_model (
   input  wire logic        sys_clk_in,
   input  wire logic        hready_in,
   input  wire logic [31:0] hrdata_in,
   output logic             hsel_out,
   output logic [31:0]      haddr_out,
   output logic [1:0]       htrans_out,
   output logic             hwrite_out,
   output logic [2:0]       hsize_out,
   output logic [31:0]      hwdata_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // bus idle at time zero
   initial begin
      hsel_out = 1'b0;
      haddr_out = 32'h0;
      htrans_out = 2'h0;
      hwrite_out = 1'b0;
      hsize_out = 3'h2;
      hwdata_out = 32'h0;
   end
   // call just after a rising edge; returns just after the data phase ends
   task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
      hsel_out <= 1'b1;
      htrans_out <= 2'h2;
      haddr_out <= {22'h0, idx, 2'h0};
      hwrite_out <= wr;
      @(posedge sys_clk_in);
      while (!hready_in) @(posedge sys_clk_in);
      hsel_out <= 1'b0;
      htrans_out <= 2'h0;
      hwdata_out <= wd;
      @(posedge sys_clk_in);
      while (!hready_in) @(posedge sys_clk_in);
      rd = hrdata_in;
      // released data lines show no stale value
      hwdata_out <= ~wd;
   endtask
endmodule // seirq_host_model

// ===== testbench/tb_sd_host_error_irq_status_enable.sv
module tb_sd_host_error_irq_status_enable;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] NS = 8'h30, ES = 8'h32, NE = 8'h34, EE = 8'h36, NG = 8'h38;
   // strobe pattern per error case and the flag it raises (11: none)
   localparam logic [16:0] EV [15] = '{17'h00001, 17'h00801, 17'h00002, 17'h00040, 17'h02040, 17'h00004,
      17'h00008, 17'h00080, 17'h00080, 17'h00010, 17'h0C100, 17'h08100, 17'h04100, 17'h00020, 17'h00000};
   localparam int FB [15] = '{10, 11, 9, 9, 11, 6, 5, 5, 11, 4, 3, 2, 1, 7, 8};
   // cases above also cover bits 6 to 1
   logic        sys_clk = 1'b0;
   logic        rstn = 1'b0;
   logic [16:0] ev = '0;              // event strobes and qualifiers
   logic [4:0]  astop = '0;           // auto stop fault levels
   logic [2:0]  tok = '0;             // write crc status token
   logic [5:0]  cmd_idx = '0;
   logic [5:0]  rsp_idx = '0;
   logic        sd_clk = 1'b0;        // card clock, still outside the response timer tests
   logic [3:0]  pins_n = 4'hF;        // a, b, c and card pins
   logic [7:0]  nev = '0;             // normal event pulses
   logic [15:0] lf = 16'h0002;        // lfsr state
   logic [15:0] en, fx;
   logic [31:0] rd;
   wire         hsel, hwrite, hrdy, hresp, irq;
   wire  [1:0]  htrans;
   wire  [2:0]  hsize;
   wire  [31:0] haddr, hwdata, hrdata;
   int          error_cnt = 0;
   int          checks_done = 0;
   seirq_host_model u_host (.sys_clk_in(sys_clk), .hready_in(hrdy), .hrdata_in(hrdata), .hsel_out(hsel),
      .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize), .hwdata_out(hwdata));
   seirq_core u_dut (.sys_clk_in(sys_clk), .rstn_in(rstn), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
      .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hrdy), .hreadyout_out(hrdy),
      .hresp_out(hresp), .hrdata_out(hrdata), .tuning_fault_in(ev[0]), .tuning_active_in(ev[11]),
      .xfer_active_in(ev[12]), .adma_fault_in(ev[1]), .desc_fetched_in(ev[6]), .desc_valid_in(ev[13]),
      .auto_stop_faults_in(astop), .power_withdrawn_in(ev[5]), .data_end_bit_zero_in(ev[2]),
      .read_crc_bad_in(ev[3]), .wr_token_valid_in(ev[7]), .wr_token_in(tok), .data_timeout_in(ev[4]),
      .cmd_sent_in(ev[9]), .cmd_issued_idx_in(cmd_idx), .resp_start_in(ev[10]), .resp_done_in(ev[8]),
      .resp_idx_in(rsp_idx), .resp_end_bit_in(ev[14]), .resp_crc_ok_in(ev[15]), .sd_clk_in(sd_clk),
      .retune_req_in(ev[16]), .int_a_n_in(pins_n[0]), .int_b_n_in(pins_n[1]), .int_c_n_in(pins_n[2]),
      .card_irq_n_in(pins_n[3]), .normal_event_in(nev), .irq_out(irq));
   always #50 sys_clk = ~sys_clk;
   function automatic logic [15:0] nxt(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   // only enabled, implemented flags can latch
   function automatic logic [15:0] gate(input logic [15:0] evm, input logic [15:0] enm);
      return evm & enm & 16'h07FF;
   endfunction
   // status bit of line a, b, c, card pin or retune source
   function automatic logic [15:0] lbit(input int j);
      return (j == 3) ? 16'h0100 : (j == 4) ? 16'h1000 : (16'h0200 << j);
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] i, input logic [31:0] d);
      u_host.xfer(1'b1, i, d, rd);
   endtask
   task automatic rdc(input string nm, input logic [7:0] i, input logic [31:0] exp);
      u_host.xfer(1'b0, i, 32'h0, rd);
      chk(nm, exp, rd);
   endtask
   // card clock periods of eight bench cycles, slow enough for the synchroniser
   task automatic sdk(input int n);
      repeat (n) begin
         sd_clk <= 1'b1;
         cyc(4);
         sd_clk <= 1'b0;
         cyc(4);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // whole run needs under two thousand cycles
   initial begin
      cyc(20000);
      error_cnt++;
      finish_test();
   end
   initial begin
      cyc(20);
      rstn <= 1'b1;
      cyc(1);
      for (int k = 0; k < 7; k++) rdc("reset value", NS + 8'(2 * k), 32'h0);
      for (int k = 0; k < 4; k++) begin
         wr(NE + 8'(2 * k), 32'hFFFF);
         rdc("enable bits", NE + 8'(2 * k), k[0] ? 32'h07FF : 32'h1FFF);
      end
      $display("test reset and enables done");
      // each error case once with its enable clear, once with it set
      for (int p = 0; p < 2; p++) begin
         for (int k = 0; k < 15; k++) begin
            lf = nxt(lf);
            en = (p == 1) ? (lf | (16'h1 << FB[k])) : (lf & ~(16'h1 << FB[k]));
            wr(EE, {16'h0, en});
            cmd_idx <= lf[5:0];
            rsp_idx <= (k == 10) ? lf[5:0] + 6'h1 : lf[5:0];
            tok <= (k == 8) ? 3'h2 : (lf[8:6] == 3'h2) ? 3'h7 : lf[8:6];
            astop <= (k == 14) ? {lf[12:9], 1'b1} : 5'h0;
            ev <= EV[k];
            cyc(1);
            ev <= '0;
            astop <= '0;
            fx = gate(16'h1 << FB[k], en);
            rdc("error flags", ES, {16'h0, fx});
            rdc("error summary", NS, (fx != 16'h0) ? 32'h8000 : 32'h0);
            chk("irq line", {31'h0, |fx}, {31'h0, irq});
            wr(ES, 32'h0);
            rdc("flags after zero write", ES, {16'h0, fx});
            wr(ES, 32'hFFFF);
            rdc("flags after clear", ES, 32'h0);
         end
      end
      wr(EE, 32'h07FF);
      ev <= 17'h01009;
      cyc(1);
      ev <= '0;
      rdc("tuning priority", ES, 32'h0400);
      wr(ES, 32'h07FF);
      ev <= 17'h00200;
      cyc(1);
      ev <= '0;
      sdk(63);
      rdc("no timeout yet", ES, 32'h0);
      sdk(1);
      rdc("response timeout", ES, 32'h0001);
      wr(ES, 32'h0001);
      ev <= 17'h00200;
      cyc(1);
      ev <= 17'h00400;
      cyc(1);
      ev <= '0;
      sdk(70);
      rdc("answered command", ES, 32'h0);
      $display("test error flags done");
      for (int k = 0; k < 4; k++) begin
         lf = nxt(lf);
         wr(NE, {16'h0, lf});
         wr(NG, {16'h0, nxt(lf)});
         nev <= lf[15:8];
         cyc(1);
         nev <= '0;
         fx = {8'h0, lf[15:8] & lf[7:0]};
         rdc("normal status", NS, {16'h0, fx});
         chk("irq line", {31'h0, |(fx & nxt(lf))}, {31'h0, irq});
         wr(NS, 32'h00FF);
      end
      $display("test normal events done");
      wr(NE, 32'h1F00);
      wr(NG, 32'h1F00);
      for (int j = 0; j < 5; j++) begin
         if (j < 4)
            pins_n <= ~(4'h1 << j);
         else
            ev <= 17'h10000;
         cyc(6);
         rdc("line status", NS, {16'h0, lbit(j)});
         chk("irq line", 32'h1, {31'h0, irq});
         wr(NE, {16'h0, 16'h1F00 & ~lbit(j)});
         rdc("masked line", NS, 32'h0);
         chk("irq line", 32'h0, {31'h0, irq});
         pins_n <= 4'hF;
         ev <= '0;
         cyc(6);
         wr(NE, 32'h1F00);
         rdc("line released", NS, 32'h0);
      end
      $display("test shared lines done");
      finish_test();
   end
endmodule // tb_sd_host_error_irq_status_enable
